// >>> dpm_defs.svh
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

// Pin timing, ns, and derived counts at 100 MHz (10 ns period)
`define DPM_CLK_NS          10
`define DPM_ACCESS_NS       25
`define DPM_ACCESS_CYC      ((`DPM_ACCESS_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_WRITE_NS        22
`define DPM_WRITE_CYC       ((`DPM_WRITE_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_FLOW_NS         35
`define DPM_FLOW_CYC        ((`DPM_FLOW_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_TOKPULSE_NS     12
`define DPM_TOKPULSE_CYC    ((`DPM_TOKPULSE_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_BUSYSET_NS      20
`define DPM_BUSYSET_CYC     ((`DPM_BUSYSET_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)

// Address layout
`define DPM_AW              17
`define DPM_DW              9
`define DPM_TOK_AW          3
`define DPM_MBOX_RIGHT      17'h1ffff
`define DPM_MBOX_LEFT       17'h1fffe

`endif

// >>> dpm_pkg.sv
package dpm_pkg;
	`include "dpm_defs.svh"

	typedef enum logic [1:0]
	{
		DPM_CMD_READ  = 2'h0,
		DPM_CMD_WRITE = 2'h1,
		DPM_CMD_TOKRD = 2'h2,
		DPM_CMD_TOKWR = 2'h3
	} dpm_cmd_e;

	typedef struct packed
	{
		dpm_cmd_e               cmd;
		logic [`DPM_AW-1:0]     addr;
		logic [`DPM_DW-1:0]     wdata;
	} dpm_req_s;

	typedef struct packed
	{
		logic                   sel_n;
		logic                   token_select_n;
		logic                   wr_n;
		logic                   oe_n;
		logic [`DPM_AW-1:0]     addr;
	} dpm_pins_s;
endpackage

// >>> dpm_sync.sv
`timescale 1ns/100ps
module dpm_sync
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rstn_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta <= {W{1'b1}};
			q_o  <= {W{1'b1}};
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// >>> dpm_host.sv
`timescale 1ns/100ps
//
// Notes on behaviour
// - Writes end by strobe; select-ended also fine
// - Wait flowthrough delay reading other's write
// - Array read asserts enable and select
// - Token read uses token select, enable
// - Delay slave writes until busy settles
// - Request token by zero, read back ownership
// - Deassert token select before token readback
// - Token select chips latches, addr bits 0-2
// - Both selects low forbidden; decode table
//
`include "dpm_defs.svh"
module dpm_host
	import dpm_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	// Request side
	input  wire logic                 req_valid_i,
	input  wire dpm_pkg::dpm_req_s    req_i,
	output logic                      req_ready_o,
	output logic                      rsp_valid_o,
	output logic [`DPM_DW-1:0]        rsp_data_o,
	output logic                      rsp_busy_o,
	output logic                      mbox_irq_o,
	// Port pins
	output dpm_pkg::dpm_pins_s        pins_o,
	input  wire logic [`DPM_DW-1:0]   data_i,
	output logic [`DPM_DW-1:0]        data_o,
	output logic                      data_oe_o,
	input  wire logic                 busy_n_i,
	input  wire logic                 int_n_i
);
	import dpm_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [4:0]
	{
		ST_IDLE   = 5'b00001,
		ST_SETTLE = 5'b00010,
		ST_ACT    = 5'b00100,
		ST_GAP    = 5'b01000,
		ST_FLOW   = 5'b10000
	} dpm_state_e;

	dpm_state_e        state;
	dpm_req_s          cur;
	logic [2:0]        cnt;
	logic              busy_n_s;
	logic              int_n_s;
	logic              busy_seen;

	function automatic logic is_write(input dpm_cmd_e c);
		is_write = (c == DPM_CMD_WRITE) || (c == DPM_CMD_TOKWR);
	endfunction

	function automatic logic is_token(input dpm_cmd_e c);
		is_token = (c == DPM_CMD_TOKRD) || (c == DPM_CMD_TOKWR);
	endfunction

	dpm_sync #(.W(2)) u_sync
	(
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.d_i       ({busy_n_i, int_n_i}),
		.q_o       ({busy_n_s, int_n_s})
	);

	assign req_ready_o = (state == ST_IDLE);
	assign mbox_irq_o  = !int_n_s;

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state <= ST_IDLE;
			cur   <= '0;
			cnt   <= 3'h0;
		end
		else
		begin
			unique case (state)
			ST_IDLE:
				if (req_valid_i)
				begin
					cur   <= req_i;
					cnt   <= 3'(`DPM_BUSYSET_CYC);
					state <= ST_SETTLE;
				end
			ST_SETTLE:
				if (cnt <= 3'h1)
				begin
					cnt   <= is_write(cur.cmd) ? 3'(`DPM_WRITE_CYC)
						: 3'(`DPM_ACCESS_CYC);
					state <= ST_ACT;
				end
				else
					cnt <= cnt - 3'h1;
			ST_ACT:
				if (cnt <= 3'h1)
				begin
					cnt   <= 3'(`DPM_TOKPULSE_CYC);
					state <= ST_GAP;
				end
				else
					cnt <= cnt - 3'h1;
			ST_GAP:
				if (cnt <= 3'h1)
				begin
					cnt   <= 3'(`DPM_FLOW_CYC);
					state <= ST_FLOW;
				end
				else
					cnt <= cnt - 3'h1;
			ST_FLOW:
				if (cnt <= 3'h1)
					state <= ST_IDLE;
				else
					cnt <= cnt - 3'h1;
			endcase
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pins_o    <= '{sel_n: 1'b1, token_select_n: 1'b1, wr_n: 1'b1,
				oe_n: 1'b1, addr: '0};
			data_o    <= '0;
			data_oe_o <= 1'b0;
		end
		else if (state == ST_IDLE && req_valid_i)
		begin
			// Address first with strobes high
			pins_o.addr <= is_token(req_i.cmd)
				? {{(`DPM_AW-`DPM_TOK_AW){1'b0}},
				req_i.addr[`DPM_TOK_AW-1:0]} : req_i.addr;
			data_o <= is_token(req_i.cmd)
				? {{(`DPM_DW-1){1'b1}}, req_i.wdata[0]}
				: req_i.wdata;
		end
		else if (state == ST_SETTLE && cnt <= 3'h1)
		begin
			// Never both selects low
			pins_o.sel_n          <= is_token(cur.cmd);
			pins_o.token_select_n <= !is_token(cur.cmd);
			pins_o.oe_n           <= is_write(cur.cmd);
			pins_o.wr_n           <= !is_write(cur.cmd);
			data_oe_o             <= is_write(cur.cmd);
		end
		else if (state == ST_ACT && cnt <= 3'h1)
		begin
			// Strobe and both selects rise on the same edge, ending the write
			pins_o.wr_n           <= 1'b1;
			pins_o.sel_n          <= 1'b1;
			pins_o.token_select_n <= 1'b1;
			pins_o.oe_n           <= 1'b1;
			data_oe_o             <= 1'b0;
		end
	end

	// ****************************************
	// Response
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= '0;
			rsp_busy_o  <= 1'b0;
			busy_seen   <= 1'b0;
		end
		else
		begin
			rsp_valid_o <= (state == ST_FLOW) && (cnt <= 3'h1);
			if (state == ST_IDLE)
				busy_seen <= 1'b0;
			else if (state == ST_ACT && !busy_n_s)
				busy_seen <= 1'b1;
			if (state == ST_ACT && cnt <= 3'h1 && !is_write(cur.cmd))
				rsp_data_o <= is_token(cur.cmd)
					? {`DPM_DW{data_i[0]}} : data_i;
			if (state == ST_FLOW && cnt <= 3'h1)
				rsp_busy_o <= busy_seen;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_SEL_EXCL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!(!pins_o.sel_n && !pins_o.token_select_n))
		else $error("both selects low");
	AST_TOK_ADDR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!pins_o.token_select_n |-> pins_o.addr[`DPM_AW-1:`DPM_TOK_AW] == '0)
		else $error("token address high bits set");
	AST_WR_DATA: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!pins_o.wr_n |-> data_oe_o && pins_o.oe_n)
		else $error("write without data drive");
	AST_RD_OE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(!pins_o.sel_n && pins_o.wr_n) |-> !pins_o.oe_n)
		else $error("read without output enable");
	AST_TOK_GAP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(pins_o.token_select_n) |-> pins_o.token_select_n[*2])
		else $error("token select gap too short");
	AST_SETTLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(pins_o.wr_n) |-> $past(state, 1) == ST_SETTLE)
		else $error("write without settle");
	AST_RSP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(req_ready_o) |-> ##[4:20] rsp_valid_o)
		else $error("response late");
	AST_TOK_BIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(!pins_o.token_select_n && data_oe_o) |->
		data_o[`DPM_DW-1:1] == '1)
		else $error("token write upper bits");
endmodule

// >>> dpm_dev_model.sv
`timescale 1ns/100ps
// ************
// Device port
// ************
module dpm_dev_model
	import dpm_pkg::*;
(
	// Pins
	input  wire dpm_pkg::dpm_pins_s pins_i,
	input  wire logic [8:0]         bus_i,
	output logic [8:0]              bus_o,
	// Flags
	input  wire logic               contend_i,
	output logic                    busy_n_o,
	output logic                    int_n_o
);
	logic [8:0]  mem [logic [16:0]];
	logic        own [2][8];
	logic        req [2][8];
	logic [16:0] ra, wa;
	logic [8:0]  wd, last;
	logic        wtok, tokq;
	wire         sel  = !pins_i.sel_n;
	wire         tsel = !pins_i.token_select_n;
	wire         wact = !pins_i.wr_n && (sel || tsel);
	wire         ract = !pins_i.oe_n && pins_i.wr_n && sel;
	wire         tact = !pins_i.oe_n && pins_i.wr_n && tsel && !sel;
	assign busy_n_o = !contend_i;
	initial
	begin
		int_n_o = 1'b1;
		last = 9'h000;
		tokq = 1'b1;
		foreach (own[p, i])
		begin
			own[p][i] = 1'b0;
			req[p][i] = 1'b0;
		end
	end
	task automatic tokw(input int p, input logic [2:0] i, input logic b);
		if (!b && !own[1-p][i])
			own[p][i] = 1'b1;
		else if (!b)
			req[p][i] = 1'b1;
		else if (own[p][i])
		begin
			own[p][i] = 1'b0;
			own[1-p][i] = req[1-p][i];
			req[1-p][i] = 1'b0;
		end
		else
			req[p][i] = 1'b0;
	endtask
	// Far port writing an array word
	task automatic rt_wr(input logic [16:0] a, input logic [8:0] d);
		mem[a] = d;
		if (a == 17'h1fffe)
			int_n_o = 1'b0;
	endtask
	always @*
	begin
		if (wact)
		begin
			wtok = tsel;
			wa = pins_i.addr;
			wd = bus_i;
		end
		if (ract)
			ra = pins_i.addr;
	end
	always @(negedge wact)
		if (wtok === 1'b1)
			tokw(0, wa[2:0], wd[0]);
		else if (wtok === 1'b0 && busy_n_o)
			mem[wa] = wd;
	always @(posedge tact)
		tokq = !own[0][pins_i.addr[2:0]];
	always @(negedge ract)
		if (ra == 17'h1fffe && busy_n_o)
			int_n_o = 1'b1;
	// Released bus shows the inverse of the last driven word
	always @(ract or tact or tokq or pins_i or last)
		if (ract === 1'b1 && mem.exists(pins_i.addr))
		begin
			bus_o = mem[pins_i.addr];
			last = bus_o;
		end
		else if (tact === 1'b1)
		begin
			bus_o = {9{tokq}};
			last = bus_o;
		end
		else
			bus_o = ~last;
endmodule

// >>> test_dual_port_arbiter_mailbox_token.sv
`timescale 1ns/100ps
// ************
// Bench
// ************
module test_dual_port_arbiter_mailbox_token;
	import dpm_pkg::*;
	typedef struct packed
	{
		dpm_req_s   r;
		logic       chk;
		logic [8:0] exp;
	} dpm_row_s;
	logic       clk_sys_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic       vld = 1'b0;
	logic       contend = 1'b0;
	dpm_req_s   req = '0;
	logic       rdy, rsp_v, rsp_b, irq, doe, busy_n, int_n;
	logic [8:0] rdat, dout, dbus;
	dpm_pins_s  pins;
	wire [4:0]  strobes = {pins.sel_n, pins.token_select_n, pins.wr_n,
		pins.oe_n, doe};
	int         error_cnt = 0;
	int         samples_checked = 0;
	dpm_row_s   rows [8] = '{
		'{'{DPM_CMD_WRITE, 17'h00005, 9'h1a5}, 1'b0, 9'h000},
		'{'{DPM_CMD_READ, 17'h00005, 9'h000}, 1'b1, 9'h1a5},
		'{'{DPM_CMD_WRITE, 17'h1ffff, 9'h055}, 1'b0, 9'h000},
		'{'{DPM_CMD_READ, 17'h1ffff, 9'h000}, 1'b1, 9'h055},
		'{'{DPM_CMD_TOKWR, 17'h1fff3, 9'h1fe}, 1'b0, 9'h000},
		'{'{DPM_CMD_TOKRD, 17'h00003, 9'h000}, 1'b1, 9'h000},
		'{'{DPM_CMD_TOKWR, 17'h00003, 9'h001}, 1'b0, 9'h000},
		'{'{DPM_CMD_TOKRD, 17'h1fffb, 9'h000}, 1'b1, 9'h1ff}};
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	error_cnt++; $display("BAD %s exp %h seen %h", n, e, s); end end
	always #5 clk_sys_i = ~clk_sys_i;
	dpm_host dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.req_valid_i(vld), .req_i(req), .req_ready_o(rdy),
		.rsp_valid_o(rsp_v), .rsp_data_o(rdat), .rsp_busy_o(rsp_b),
		.mbox_irq_o(irq), .pins_o(pins), .data_i(dbus), .data_o(dout),
		.data_oe_o(doe), .busy_n_i(busy_n), .int_n_i(int_n));
	dpm_dev_model dev_u (.pins_i(pins), .bus_i(dout), .bus_o(dbus),
		.contend_i(contend), .busy_n_o(busy_n), .int_n_o(int_n));
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic xfer(input dpm_req_s r);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		req = r;
		vld = 1'b1;
		@(negedge clk_sys_i);
		vld = 1'b0;
		`CHK("ready", 1'b0, rdy)
		while (rsp_v !== 1'b1 && n < 60)
		begin
			@(negedge clk_sys_i);
			n++;
		end
		`CHK("response", 1'b1, rsp_v)
		`CHK("ready back", 1'b1, rdy)
	endtask
	initial
	begin
		#40000;
		error_cnt++;
		$display("BAD watchdog exp done seen hang");
		test_done;
	end
	initial
	begin
		repeat (12) @(negedge clk_sys_i);
		`CHK("strobes", 5'h1e, strobes)
		rstn_i = 1'b1;
		$display("test reset done");
		foreach (rows[k])
		begin
			xfer(rows[k].r);
			if (rows[k].chk)
				`CHK("row data", rows[k].exp, rdat)
		end
		$display("test table done");
		dev_u.rt_wr(17'h1fffe, 9'h0c3);
		repeat (4) @(negedge clk_sys_i);
		`CHK("irq set", 1'b1, irq)
		xfer('{DPM_CMD_READ, 17'h1ffff, 9'h000});
		`CHK("irq kept", 1'b1, irq)
		xfer('{DPM_CMD_READ, 17'h1fffe, 9'h000});
		`CHK("mailbox", 9'h0c3, rdat)
		repeat (4) @(negedge clk_sys_i);
		`CHK("irq clear", 1'b0, irq)
		$display("test mailbox done");
		dev_u.rt_wr(17'h1fffe, 9'h03c);
		contend = 1'b1;
		xfer('{DPM_CMD_READ, 17'h1fffe, 9'h000});
		`CHK("busy seen", 1'b1, rsp_b)
		repeat (4) @(negedge clk_sys_i);
		`CHK("irq held", 1'b1, irq)
		xfer('{DPM_CMD_WRITE, 17'h00005, 9'h0ff});
		contend = 1'b0;
		xfer('{DPM_CMD_READ, 17'h00005, 9'h000});
		`CHK("no write", 9'h1a5, rdat)
		`CHK("busy free", 1'b0, rsp_b)
		$display("test busy done");
		dev_u.tokw(1, 3'h2, 1'b0);
		xfer('{DPM_CMD_TOKWR, 17'h00002, 9'h000});
		xfer('{DPM_CMD_TOKRD, 17'h00002, 9'h000});
		`CHK("token held", 9'h1ff, rdat)
		dev_u.tokw(1, 3'h2, 1'b1);
		xfer('{DPM_CMD_TOKRD, 17'h00002, 9'h000});
		`CHK("token passed", 9'h000, rdat)
		$display("test token done");
		@(negedge clk_sys_i);
		req = '{DPM_CMD_READ, 17'h00005, 9'h000};
		vld = 1'b1;
		@(negedge clk_sys_i);
		vld = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		`CHK("strobes on", 5'h0c, strobes)
		rstn_i = 1'b0;
		@(negedge clk_sys_i);
		`CHK("strobes reset", 5'h1e, strobes)
		`CHK("ready reset", 1'b1, rdy)
		rstn_i = 1'b1;
		xfer('{DPM_CMD_READ, 17'h00005, 9'h000});
		`CHK("after reset", 9'h1a5, rdat)
		`CHK("irq after reset", 1'b1, irq)
		$display("test reset again done");
		test_done;
	end
endmodule
